// ---- design/sfc_buf.sv ----
// Two-entry buffer with registered valid and ready
`default_nettype none
module sfc_buf #(
    parameter int unsigned W = 9
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [W-1:0] spare;
    logic [W-1:0] next_spare;
    logic [W-1:0] next_out_data;
    logic push;
    logic pop;

    // Head word sits in out_data, second word in spare
    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_cnt = cnt;
        next_spare = spare;
        next_out_data = out_data;
        if (push && pop)
        begin
            if (cnt == 2'h1)
                next_out_data = in_data;
            else
            begin
                next_out_data = spare;
                next_spare = in_data;
            end
        end
        else if (pop)
        begin
            next_out_data = spare;
            next_cnt = cnt - 2'h1;
        end
        else if (push)
        begin
            if (cnt == 2'h0)
                next_out_data = in_data;
            else
                next_spare = in_data;
            next_cnt = cnt + 2'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt <= 2'h0;
            spare <= '0;
            out_data <= '0;
            out_valid <= 1'b0;
            in_ready <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            spare <= next_spare;
            out_data <= next_out_data;
            out_valid <= (next_cnt != 2'h0);
            in_ready <= (next_cnt != 2'h2);
        end
    end
endmodule : sfc_buf
`default_nettype wire

// ---- design/sfc_consts.svh ----
// Constants of the serial port with character flow control
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
`define SFC_CLK_HZ 100000000
`define SFC_DC1 8'h11
`define SFC_DC2 8'h12
`define SFC_DC3 8'h13
`define SFC_DC4 8'h14
`define SFC_LATE_LIMIT 4'ha
`define SFC_BITS_ONE_STOP 4'ha
`define SFC_BITS_TWO_STOP 4'hb
`define SFC_BAUD_0 50
`define SFC_BAUD_1 100
`define SFC_BAUD_2 110
`define SFC_BAUD_3 150
`define SFC_BAUD_4 200
`define SFC_BAUD_5 300
`define SFC_BAUD_6 600
`define SFC_BAUD_7 1200
`define SFC_BAUD_8 2400
`define SFC_BAUD_9 4800
`define SFC_BAUD_10 9600
`endif

// ---- design/sfc_pkg.sv ----
// Types of the serial port with character flow control
`default_nettype none
package sfc_pkg;
    typedef enum logic [2:0] {
        SFC_MODE_IDLE = 3'h1,
        SFC_MODE_READ = 3'h2,
        SFC_MODE_PUNCH = 3'h4
    } sfc_mode_e;
    typedef enum logic [1:0] {
        SFC_TX_IDLE = 2'h1,
        SFC_TX_SHIFT = 2'h2
    } sfc_tx_e;
    typedef enum logic [3:0] {
        SFC_RX_IDLE = 4'h1,
        SFC_RX_START = 4'h2,
        SFC_RX_DATA = 4'h4,
        SFC_RX_STOP = 4'h8
    } sfc_rx_e;
    typedef struct packed {
        logic late;
        logic [7:0] data;
    } sfc_rx_s;
endpackage : sfc_pkg
`default_nettype wire

// ---- design/sfc_top.sv ----
// Serial port with DC1..DC4 character flow control and clear-to-send pacing
`default_nettype none
`include "sfc_consts.svh"
module sfc_top #(
    parameter int unsigned CLK_HZ = `SFC_CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] baud_sel,
    input wire logic two_stop,
    input wire logic rxd,
    output logic txd,
    input wire logic cts,
    input wire logic read_start,
    input wire logic read_hold,
    input wire logic read_done,
    output sfc_pkg::sfc_rx_s rx_char,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic punch_start,
    input wire logic [7:0] punch_data,
    input wire logic punch_valid,
    output logic punch_ready,
    input wire logic punch_end,
    input wire logic alarm_clear,
    output logic overrun_alarm
);
    import sfc_pkg::*;

    // Cycles per bit for a rate code; unknown codes run at the top rate
    function automatic logic [31:0] bit_cycles(input logic [3:0] sel);
        int unsigned baud;
        case (sel)
            4'h0: baud = `SFC_BAUD_0;
            4'h1: baud = `SFC_BAUD_1;
            4'h2: baud = `SFC_BAUD_2;
            4'h3: baud = `SFC_BAUD_3;
            4'h4: baud = `SFC_BAUD_4;
            4'h5: baud = `SFC_BAUD_5;
            4'h6: baud = `SFC_BAUD_6;
            4'h7: baud = `SFC_BAUD_7;
            4'h8: baud = `SFC_BAUD_8;
            4'h9: baud = `SFC_BAUD_9;
            default: baud = `SFC_BAUD_10;
        endcase
        return 32'(CLK_HZ / baud);
    endfunction : bit_cycles

    sfc_rx_e rx_st, next_rx_st;
    logic [31:0] rx_tmr, next_rx_tmr;
    logic [2:0] rx_bit, next_rx_bit;
    logic [7:0] rx_sh, next_rx_sh;
    logic rx_done, next_rx_done;
    sfc_mode_e mode, next_mode;
    logic [3:0] pend, next_pend;
    logic local_pause, next_local_pause;
    logic peer_pause, next_peer_pause;
    logic [3:0] late_cnt, next_late_cnt;
    logic end_req, next_end_req;
    logic next_alarm;
    logic pause_want;
    logic buf_in_ready;
    sfc_tx_e tx_st, next_tx_st;
    logic [31:0] tx_tmr, next_tx_tmr;
    logic [10:0] tx_sh, next_tx_sh;
    logic [3:0] tx_cnt, next_tx_cnt;
    logic next_txd;
    logic [7:0] hold, next_hold;
    logic hold_valid, next_hold_valid;
    logic [3:0] tx_take;
    logic [7:0] tx_code;

    // Receiver: mid-bit sampling, frames with a bad stop bit are dropped
    always_comb
    begin
        next_rx_st = rx_st;
        next_rx_tmr = rx_tmr;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_rx_done = 1'b0;
        case (rx_st)
            SFC_RX_IDLE:
                if (!rxd)
                begin
                    next_rx_tmr = bit_cycles(baud_sel) >> 1;
                    next_rx_st = SFC_RX_START;
                end
            SFC_RX_START:
                if (rx_tmr != 32'h0)
                    next_rx_tmr = rx_tmr - 32'h1;
                else if (rxd)
                    next_rx_st = SFC_RX_IDLE;
                else
                begin
                    next_rx_tmr = bit_cycles(baud_sel) - 32'h1;
                    next_rx_bit = 3'h0;
                    next_rx_st = SFC_RX_DATA;
                end
            SFC_RX_DATA:
                if (rx_tmr != 32'h0)
                    next_rx_tmr = rx_tmr - 32'h1;
                else
                begin
                    next_rx_sh = {rxd, rx_sh[7:1]};
                    next_rx_tmr = bit_cycles(baud_sel) - 32'h1;
                    next_rx_bit = rx_bit + 3'h1;
                    if (rx_bit == 3'h7)
                        next_rx_st = SFC_RX_STOP;
                end
            SFC_RX_STOP:
                if (rx_tmr != 32'h0)
                    next_rx_tmr = rx_tmr - 32'h1;
                else
                begin
                    next_rx_done = rxd;
                    next_rx_st = SFC_RX_IDLE;
                end
            default:
                next_rx_st = SFC_RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rx_st <= SFC_RX_IDLE;
            rx_tmr <= 32'h0;
            rx_bit <= 3'h0;
            rx_sh <= 8'h00;
            rx_done <= 1'b0;
        end
        else
        begin
            rx_st <= next_rx_st;
            rx_tmr <= next_rx_tmr;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            rx_done <= next_rx_done;
        end
    end

    // Received characters of a read pass through the two-entry buffer
    sfc_buf #(
        .W($bits(sfc_rx_s))
    ) u_rx_buf (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(rx_done && mode == SFC_MODE_READ),
        .in_data({local_pause, rx_sh}),
        .in_ready(buf_in_ready),
        .out_valid(rx_valid),
        .out_data(rx_char),
        .out_ready(rx_ready)
    );

    // Flow control: transfer mode, pending codes, pauses and the alarm
    always_comb
    begin
        pause_want = read_hold || !buf_in_ready;
        next_mode = mode;
        next_pend = pend & ~tx_take;
        next_local_pause = local_pause;
        next_peer_pause = peer_pause;
        next_late_cnt = late_cnt;
        next_end_req = end_req;
        next_alarm = overrun_alarm && !alarm_clear;
        if (rx_done && local_pause)
        begin
            if (late_cnt == `SFC_LATE_LIMIT)
                next_alarm = 1'b1;
            else
                next_late_cnt = late_cnt + 4'h1;
        end
        case (mode)
            SFC_MODE_IDLE:
                if (read_start)
                begin
                    next_mode = SFC_MODE_READ;
                    next_pend = {next_pend[3], 1'b0, next_pend[1], 1'b1};
                    next_local_pause = 1'b0;
                end
                else if (punch_start)
                begin
                    next_mode = SFC_MODE_PUNCH;
                    next_pend[1] = 1'b1;
                    next_peer_pause = 1'b0;
                    next_end_req = 1'b0;
                end
            SFC_MODE_READ:
                if (read_done)
                begin
                    next_mode = SFC_MODE_IDLE;
                    next_pend = {next_pend[3], 1'b1, next_pend[1], 1'b0};
                    next_local_pause = 1'b0;
                end
                else if (pause_want && !local_pause)
                begin
                    next_pend = {next_pend[3], 1'b1, next_pend[1], 1'b0};
                    next_local_pause = 1'b1;
                    next_late_cnt = 4'h0;
                end
                else if (!pause_want && local_pause)
                begin
                    next_pend = {next_pend[3], 1'b0, next_pend[1], 1'b1};
                    next_local_pause = 1'b0;
                end
            SFC_MODE_PUNCH:
            begin
                if (rx_done && rx_sh == `SFC_DC3)
                    next_peer_pause = 1'b1;
                else if (rx_done && rx_sh == `SFC_DC1)
                    next_peer_pause = 1'b0;
                if (punch_end)
                    next_end_req = 1'b1;
                if (end_req && !hold_valid)
                begin
                    next_pend[3] = 1'b1;
                    next_mode = SFC_MODE_IDLE;
                end
            end
            default:
                next_mode = SFC_MODE_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mode <= SFC_MODE_IDLE;
            pend <= 4'h0;
            local_pause <= 1'b0;
            peer_pause <= 1'b0;
            late_cnt <= 4'h0;
            end_req <= 1'b0;
            overrun_alarm <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            pend <= next_pend;
            local_pause <= next_local_pause;
            peer_pause <= next_peer_pause;
            late_cnt <= next_late_cnt;
            end_req <= next_end_req;
            overrun_alarm <= next_alarm;
        end
    end

    // Transmitter: codes first, then data paced by clear-to-send and DC3
    always_comb
    begin
        next_tx_st = tx_st;
        next_tx_tmr = tx_tmr;
        next_tx_sh = tx_sh;
        next_tx_cnt = tx_cnt;
        next_txd = txd;
        next_hold = hold;
        next_hold_valid = hold_valid;
        tx_take = 4'h0;
        tx_code = hold;
        if (pend[1])
            tx_code = `SFC_DC2;
        else if (pend[2])
            tx_code = `SFC_DC3;
        else if (pend[0])
            tx_code = `SFC_DC1;
        else if (pend[3])
            tx_code = `SFC_DC4;
        case (tx_st)
            SFC_TX_IDLE:
            begin
                next_txd = 1'b1;
                if (pend != 4'h0 || (hold_valid && cts && !peer_pause))
                begin
                    if (pend[1])
                        tx_take = 4'h2;
                    else if (pend[2])
                        tx_take = 4'h4;
                    else if (pend[0])
                        tx_take = 4'h1;
                    else if (pend[3])
                        tx_take = 4'h8;
                    else
                        next_hold_valid = 1'b0;
                    next_tx_sh = {2'b11, tx_code, 1'b0};
                    next_tx_cnt = two_stop ? `SFC_BITS_TWO_STOP : `SFC_BITS_ONE_STOP;
                    next_tx_tmr = bit_cycles(baud_sel) - 32'h1;
                    next_txd = 1'b0;
                    next_tx_st = SFC_TX_SHIFT;
                end
            end
            SFC_TX_SHIFT:
                if (tx_tmr != 32'h0)
                    next_tx_tmr = tx_tmr - 32'h1;
                else if (tx_cnt == 4'h1)
                begin
                    next_txd = 1'b1;
                    next_tx_st = SFC_TX_IDLE;
                end
                else
                begin
                    next_tx_cnt = tx_cnt - 4'h1;
                    next_tx_sh = {1'b1, tx_sh[10:1]};
                    next_txd = tx_sh[1];
                    next_tx_tmr = bit_cycles(baud_sel) - 32'h1;
                end
            default:
                next_tx_st = SFC_TX_IDLE;
        endcase
        if (punch_valid && punch_ready)
        begin
            next_hold = punch_data;
            next_hold_valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tx_st <= SFC_TX_IDLE;
            tx_tmr <= 32'h0;
            tx_sh <= 11'h7ff;
            tx_cnt <= 4'h0;
            txd <= 1'b1;
            hold <= 8'h00;
            hold_valid <= 1'b0;
            punch_ready <= 1'b0;
        end
        else
        begin
            tx_st <= next_tx_st;
            tx_tmr <= next_tx_tmr;
            tx_sh <= next_tx_sh;
            tx_cnt <= next_tx_cnt;
            txd <= next_txd;
            hold <= next_hold;
            hold_valid <= next_hold_valid;
            punch_ready <= next_mode == SFC_MODE_PUNCH && !next_end_req && !next_hold_valid;
        end
    end

    // Checks on flow control and framing
    property p_read_dc1;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_IDLE && read_start |=> pend[0] && mode == SFC_MODE_READ;
    endproperty
    a_read_dc1: assert property (p_read_dc1) else $error("no DC1 at read start");
    property p_pause_dc3;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_READ && !read_done && read_hold && !local_pause
            |=> pend[2] && !pend[0] && local_pause;
    endproperty
    a_pause_dc3: assert property (p_pause_dc3) else $error("no DC3 on hold");
    property p_alarm;
        @(posedge ref_clk) disable iff (reset)
        rx_done && local_pause && late_cnt == 4'ha |=> overrun_alarm;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm missed");
    property p_resume_dc1;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_READ && !read_done && !read_hold && buf_in_ready && local_pause
            |=> pend[0] && !local_pause;
    endproperty
    a_resume_dc1: assert property (p_resume_dc1) else $error("no DC1 on resume");
    property p_done_dc3;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_READ && read_done |=> pend[2] && mode == SFC_MODE_IDLE;
    endproperty
    a_done_dc3: assert property (p_done_dc3) else $error("no DC3 at read end");
    property p_punch_dc2;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_IDLE && !read_start && punch_start |=> pend[1] ##1 !pend[1];
    endproperty
    a_punch_dc2: assert property (p_punch_dc2) else $error("DC2 not sent first");
    property p_cts_stop;
        @(posedge ref_clk) disable iff (reset)
        tx_st == SFC_TX_IDLE && pend == 4'h0 && (!cts || peer_pause)
            |=> tx_st == SFC_TX_IDLE && txd;
    endproperty
    a_cts_stop: assert property (p_cts_stop) else $error("sent while held");
    property p_data_go;
        @(posedge ref_clk) disable iff (reset)
        tx_st == SFC_TX_IDLE && pend == 4'h0 && hold_valid && cts && !peer_pause
            |=> tx_st == SFC_TX_SHIFT && !txd && tx_sh[8:1] == $past(hold);
    endproperty
    a_data_go: assert property (p_data_go) else $error("data not resumed");
    property p_dc3_pause;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_PUNCH && rx_done && rx_sh == 8'h13 |=> peer_pause;
    endproperty
    a_dc3_pause: assert property (p_dc3_pause) else $error("DC3 ignored");
    property p_dc1_go;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_PUNCH && rx_done && rx_sh == 8'h11 |=> !peer_pause;
    endproperty
    a_dc1_go: assert property (p_dc1_go) else $error("DC1 ignored");
    property p_end_dc4;
        @(posedge ref_clk) disable iff (reset)
        mode == SFC_MODE_PUNCH && end_req && !hold_valid |=> pend[3];
    endproperty
    a_end_dc4: assert property (p_end_dc4) else $error("no DC4 at end");
    property p_start_bit;
        @(posedge ref_clk) disable iff (reset)
        tx_take != 4'h0 |=> !txd && tx_st == SFC_TX_SHIFT;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");
    c_read_pause: cover property (@(posedge ref_clk) local_pause ##1 !local_pause);
    c_alarm: cover property (@(posedge ref_clk) !overrun_alarm ##1 overrun_alarm);
    c_peer_pause: cover property (@(posedge ref_clk) peer_pause ##1 !peer_pause);
    c_dc4: cover property (@(posedge ref_clk) tx_take == 4'h8);
endmodule : sfc_top
`default_nettype wire

// ---- sim/sfc_peer.sv ----
// Behavioural far-end reader and punch device on the serial link
`default_nettype none
module sfc_peer #(
    parameter int BIT = 10
) (
    input wire logic ref_clk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] heard[$];
    logic [7:0] feed[$];
    int allow = 0;
    int late_extra = 0;
    initial rxd = 1'h1;
    // Decode frames from the unit: start bit, 8 bits LSB first, stop
    initial
    begin
        logic [7:0] b;
        forever
        begin
            @(negedge txd);
            repeat (BIT / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge ref_clk);
                b[i] = txd;
            end
            repeat (BIT) @(posedge ref_clk);
            heard.push_back(b);
            if (b == 8'h11)
                allow = 1000;
            if (b == 8'h13)
                allow = late_extra;
        end
    end
    // One frame onto the line, idle high afterwards
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge ref_clk);
            rxd = f[i];
            repeat (BIT - 1) @(negedge ref_clk);
        end
    endtask : send_byte
    // Data leaves only while allowed, strictly in feed order
    initial
    forever
    begin
        @(negedge ref_clk);
        if (allow > 0 && feed.size() > 0)
        begin
            allow--;
            send_byte(feed.pop_front());
        end
    end
endmodule : sfc_peer
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the flow-controlled serial port
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FRAME = 100;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic rxd;
    logic txd;
    logic cts = 1'h1;
    logic [3:0] baud_sel = 4'ha;
    logic two_stop = 1'h0;
    logic read_start = 1'h0;
    logic read_hold = 1'h0;
    logic read_done = 1'h0;
    logic rx_ready = 1'h1;
    logic punch_start = 1'h0;
    logic [7:0] punch_data = 8'h0;
    logic punch_valid = 1'h0;
    logic punch_end = 1'h0;
    logic alarm_clear = 1'h0;
    logic rx_valid;
    logic punch_ready;
    logic overrun_alarm;
    sfc_pkg::sfc_rx_s rx_char;
    logic [7:0] got[$];
    logic got_late[$];
    int checks = 0;
    int miscompares = 0;
    // 10 clocks per bit at 9600
    sfc_top #(.CLK_HZ(96000)) uut (.ref_clk(ref_clk), .reset(reset), .baud_sel(baud_sel),
        .two_stop(two_stop), .rxd(rxd), .txd(txd), .cts(cts), .read_start(read_start),
        .read_hold(read_hold), .read_done(read_done), .rx_char(rx_char),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .punch_start(punch_start),
        .punch_data(punch_data), .punch_valid(punch_valid), .punch_ready(punch_ready),
        .punch_end(punch_end), .alarm_clear(alarm_clear), .overrun_alarm(overrun_alarm));
    sfc_peer #(.BIT(10)) peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
    always #5 ref_clk = ~ref_clk;
    // Collect delivered characters; accepted at the next rising edge
    always @(negedge ref_clk)
    begin
        #1;
        if (rx_valid === 1'h1 && rx_ready === 1'h1)
        begin
            got.push_back(rx_char.data);
            got_late.push_back(rx_char.late);
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Bounded wait for a queue to reach a length
    task automatic wait_n(input logic use_got, input int n);
        int t;
        int s;
        t = 0;
        s = use_got ? got.size() : peer.heard.size();
        while (s < n && t < 30 * FRAME)
        begin
            @(negedge ref_clk);
            t++;
            s = use_got ? got.size() : peer.heard.size();
        end
        chk("queue length", n[7:0], s[7:0]);
    endtask : wait_n
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic test_reset;
        chk("txd idle", 8'h1, {7'h0, txd});
        chk("rx_valid", 8'h0, {7'h0, rx_valid});
        chk("punch_ready", 8'h0, {7'h0, punch_ready});
        chk("alarm", 8'h0, {7'h0, overrun_alarm});
    endtask : test_reset
    // Read with a user hold in the middle, no data lost or repeated
    task automatic test_read;
        for (int i = 0; i < 6; i++)
            peer.feed.push_back(8'h41 + 8'(i));
        read_start = 1'h1;
        @(negedge ref_clk);
        read_start = 1'h0;
        wait_n(1'h0, 1);
        chk("first code", 8'h11, peer.heard[0]);
        wait_n(1'h1, 2);
        read_hold = 1'h1;
        wait_n(1'h0, 2);
        chk("pause code", 8'h13, peer.heard[1]);
        repeat (3 * FRAME) @(negedge ref_clk);
        read_hold = 1'h0;
        wait_n(1'h0, 3);
        chk("resume code", 8'h11, peer.heard[2]);
        wait_n(1'h1, 6);
        for (int i = 0; i < 6; i++)
            chk("read data", 8'h41 + 8'(i), got[i]);
        // Only the character already under way when the pause began is late
        chk("late first", 8'h0, {7'h0, got_late[0]});
        chk("late paused", 8'h1, {7'h0, got_late[2]});
        chk("late resumed", 8'h0, {7'h0, got_late[5]});
        read_done = 1'h1;
        @(negedge ref_clk);
        read_done = 1'h0;
        wait_n(1'h0, 4);
        chk("end code", 8'h13, peer.heard[3]);
        got.delete();
        got_late.delete();
        peer.heard.delete();
    endtask : test_read
    // Stalled receiver; peer keeps sending extra characters after the pause
    task automatic test_alarm(input int extra, input logic exp);
        peer.late_extra = extra;
        for (int i = 0; i < 20; i++)
            peer.feed.push_back(8'h30 + 8'(i));
        rx_ready = 1'h0;
        read_start = 1'h1;
        @(negedge ref_clk);
        read_start = 1'h0;
        wait_n(1'h0, 2);
        chk("stall code", 8'h13, peer.heard[1]);
        repeat ((extra + 4) * FRAME) @(negedge ref_clk);
        chk("overrun alarm", {7'h0, exp}, {7'h0, overrun_alarm});
        peer.feed.delete();
        peer.late_extra = 0;
        rx_ready = 1'h1;
        read_done = 1'h1;
        @(negedge ref_clk);
        read_done = 1'h0;
        repeat (4 * FRAME) @(negedge ref_clk);
        alarm_clear = 1'h1;
        @(negedge ref_clk);
        alarm_clear = 1'h0;
        @(negedge ref_clk);
        chk("alarm cleared", 8'h0, {7'h0, overrun_alarm});
        got.delete();
        got_late.delete();
        peer.heard.delete();
    endtask : test_alarm
    // Offer one punch word and hold it until taken
    task automatic put_word(input logic [7:0] b);
        int t;
        t = 0;
        punch_data = b;
        punch_valid = 1'h1;
        while (punch_ready !== 1'h1 && t < 5000)
        begin
            @(negedge ref_clk);
            t++;
        end
        @(negedge ref_clk);
    endtask : put_word
    // Punch in two-stop mode with a clear-to-send pause and a DC3/DC1 pause
    task automatic test_punch;
        int n;
        int m;
        int g;
        time t0;
        baud_sel = 4'hf; // Codes above 10 run at the top rate
        two_stop = 1'h1;
        punch_start = 1'h1;
        @(negedge ref_clk);
        punch_start = 1'h0;
        fork
            begin
                // Valid stays up between words, dropped after the last
                for (int i = 0; i < 8; i++)
                    put_word(8'h60 + 8'(i));
                punch_valid = 1'h0;
            end
            begin
                // DC2 and first word back to back: 11 bit times apiece
                @(negedge txd);
                t0 = $time;
                repeat (105) @(posedge ref_clk);
                @(negedge txd);
                g = int'(($time - t0) / 10);
                chk("frame cycles", 8'h1, {7'h0, g >= 110 && g <= 111});
                wait_n(1'h0, 3);
                cts = 1'h0;
                n = peer.heard.size();
                repeat (4 * FRAME) @(negedge ref_clk);
                m = peer.heard.size();
                chk("cts stop", 8'h1, {7'h0, m <= n + 2});
                repeat (3 * FRAME) @(negedge ref_clk);
                chk("cts held", m[7:0], 8'(peer.heard.size()));
                cts = 1'h1;
                wait_n(1'h0, m + 1);
                peer.send_byte(8'h13);
                n = peer.heard.size();
                repeat (3 * FRAME) @(negedge ref_clk);
                m = peer.heard.size();
                chk("dc3 stop", 8'h1, {7'h0, m <= n + 10});
                repeat (3 * FRAME) @(negedge ref_clk);
                chk("dc3 held", m[7:0], 8'(peer.heard.size()));
                peer.send_byte(8'h11);
                wait_n(1'h0, m + 1);
            end
        join
        punch_end = 1'h1;
        @(negedge ref_clk);
        punch_end = 1'h0;
        wait_n(1'h0, 10);
        chk("start code", 8'h12, peer.heard[0]);
        for (int i = 0; i < 8; i++)
            chk("punch data", 8'h60 + 8'(i), peer.heard[i + 1]);
        chk("end code", 8'h14, peer.heard[9]);
    endtask : test_punch
    // Watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
    initial
    begin
        repeat (12) @(negedge ref_clk);
        reset = 1'h0;
        test_reset();
        test_read();
        test_alarm(8, 1'h0);
        test_alarm(12, 1'h1);
        test_punch();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
